// ---- hdl/poa_pkg.sv ----
// Package with register map, field layout and timing constants of the protection output block.
package poa_pkg;
  localparam int unsigned ClkHz          = 40000000;
  localparam int unsigned SecondS        = 1;
  localparam int unsigned CyclesPerSec   = ClkHz * SecondS;
  localparam logic [31:0] CfgIdx         = 32'h0000_0011;
  localparam logic [31:0] StatIdx        = 32'h0000_0026;
  localparam logic [31:0] PolIdx         = 32'h0000_0040;
  localparam logic [31:0] TimeIdx        = 32'h0000_0041;
  localparam logic [11:0] CfgAddr        = 12'h044;
  localparam logic [11:0] StatAddr       = 12'h098;
  localparam logic [11:0] PolAddr        = 12'h100;
  localparam logic [11:0] TimeAddr       = 12'h104;
  localparam int unsigned DelayLsb       = 12;
  localparam int unsigned DelayMsb       = 15;
  localparam int unsigned HealthyBit     = 11;
  localparam logic [15:0] AlarmMaskBits  = 16'h00fe;
  localparam logic [15:0] CfgReset       = 16'h0000;
  localparam logic        PolReset       = 1'b1;
  localparam logic [1:0]  RespOkay       = 2'b00;
  localparam logic [1:0]  RespSlvErr     = 2'b10;

  typedef struct packed {
    logic underexcitation;
    logic overspeed;
    logic underspeed;
    logic overExcitation;
    logic shortCircuit;
    logic undervoltage;
    logic overvoltage;
  } poa_alarm_t;

  typedef enum logic [1:0] {
    PoaIdle  = 2'b00,
    PoaCount = 2'b01,
    PoaTrip  = 2'b10
  } poa_state_t;

  function automatic logic [15:0] poa_align(input logic [31:0] idx);
    poa_align = {idx[13:0], 2'b00};
  endfunction
endpackage

// ---- hdl/poa_protection_output.sv ----
// Protection output with alarm mask, trip delay, polarity and healthy indicator.
// Function
// [RULE1] With polarity set and no enabled alarm, the output transistor conducts.
// [RULE2] With polarity set, an enabled alarm opens the output after the 0 to 15 s delay.
// [RULE3] With polarity cleared the output sense is reversed.
// [RULE4] Alarms whose mask bit is zero are ignored by the output but still clear the healthy indicator.
// [RULE5] The config word holds the mask in low bits and the delay in bits 15 to 12.
// [RULE6] Mask weights 2 to 128 select the seven alarms, weights 256 to 2048 are unused.
// [RULE7] The healthy indicator and status bit 11 stay high while no alarm has occurred.
// [RULE8] The first alarm clears the healthy indicator and stores the operation time.
// [RULE9] The delay restarts whenever no enabled alarm is asserted.
module poa_protection_output
  import poa_pkg::*;
#(
  parameter int unsigned SecCycles = CyclesPerSec
)
(
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire poa_pkg::poa_alarm_t alarmIn,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [11:0]       s_axi_awaddr,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  output logic [1:0]             s_axi_bresp,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  input  wire logic [11:0]       s_axi_araddr,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   protectionOutput,
  output logic                   healthyIndicator
);
  import poa_pkg::*;

  // Alarm flags come from another part of the regulator, so they are synchronised first.
  poa_alarm_t sync1_q, sync2_q;
  logic [15:0] cfg_q, cfg_d;
  logic        pol_q, pol_d;
  logic        healthy_q, healthy_d;
  logic [31:0] opTime_q, opTime_d, timeRec_q, timeRec_d, opTick_q, opTick_d;
  logic [31:0] tick_q, tick_d;
  logic [3:0]  secs_q, secs_d;
  poa_state_t  state_q, state_d;
  logic        out_q, out_d;
  logic        awHeld_q, awHeld_d, wHeld_q, wHeld_d, bvalid_q, bvalid_d;
  logic [11:0] awAddr_q, awAddr_d;
  logic [31:0] wData_q, wData_d;
  logic [3:0]  wStrb_q, wStrb_d;
  logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
  logic        rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [15:0] alarmWord, enabled;
  logic        anyEnabled, anyAlarm;
  logic [3:0]  delaySecs;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
    end
    else
    begin
      sync1_q <= alarmIn;
      sync2_q <= sync1_q;
    end
  end

  always_comb
  begin
    alarmWord  = {8'h00, sync2_q, 1'b0};                           // [RULE6]
    enabled    = alarmWord & cfg_q & AlarmMaskBits;                // [RULE4]
    anyEnabled = |enabled;
    anyAlarm   = |sync2_q;
    delaySecs  = cfg_q[DelayMsb:DelayLsb];                         // [RULE5]
  end

  // Delay state machine; the second timer is only run while an enabled alarm persists.
  always_comb
  begin
    state_d = state_q;
    tick_d  = tick_q;
    secs_d  = secs_q;
    if (!anyEnabled)
    begin
      state_d = PoaIdle;                                           // [RULE9]
      tick_d  = '0;
      secs_d  = '0;
    end
    else
    begin
      case (state_q)
        PoaIdle:
        begin
          tick_d  = '0;
          secs_d  = '0;
          state_d = (delaySecs == 4'h0) ? PoaTrip : PoaCount;      // [RULE2]
        end
        PoaCount:
        begin
          if (tick_q == SecCycles - 1)
          begin
            tick_d = '0;
            secs_d = secs_q + 4'h1;
            if (secs_q + 4'h1 == delaySecs)
            begin
              state_d = PoaTrip;                                   // [RULE2] [RULE3]
            end
          end
          else
          begin
            tick_d = tick_q + 32'h1;
          end
        end
        PoaTrip:
        begin
          state_d = PoaTrip;
        end
        default:
        begin
          state_d = PoaIdle;
        end
      endcase
    end
    // High means the transistor conducts.
    out_d = (state_d == PoaTrip) ? !pol_q : pol_q;                 // [RULE1] [RULE2] [RULE3]
  end

  always_comb
  begin
    // Seconds since reset run freely, so the record is the time in service before the alarm.
    opTick_d  = (opTick_q == SecCycles - 1) ? 32'h0 : opTick_q + 32'h1;
    opTime_d  = (opTick_q == SecCycles - 1) ? opTime_q + 32'h1 : opTime_q;
    timeRec_d = timeRec_q;
    healthy_d = healthy_q;
    if (healthy_q && anyAlarm)
    begin
      healthy_d = 1'b0;                                            // [RULE8]
      timeRec_d = opTime_q;                                        // [RULE8]
    end
  end

  // Write channel accepts address and data in either order; response follows both.
  always_comb
  begin
    awHeld_d = awHeld_q;
    wHeld_d  = wHeld_q;
    awAddr_d = awAddr_q;
    wData_d  = wData_q;
    wStrb_d  = wStrb_q;
    bvalid_d = bvalid_q;
    bresp_d  = bresp_q;
    cfg_d    = cfg_q;
    pol_d    = pol_q;
    if (s_axi_awvalid && s_axi_awready)
    begin
      awHeld_d = 1'b1;
      awAddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      wHeld_d = 1'b1;
      wData_d = s_axi_wdata;
      wStrb_d = s_axi_wstrb;
    end
    if (awHeld_q && wHeld_q && !bvalid_q)
    begin
      awHeld_d = 1'b0;
      wHeld_d  = 1'b0;
      bvalid_d = 1'b1;
      bresp_d  = RespOkay;
      case (awAddr_q & 12'hffc)
        CfgAddr:
        begin
          if (wStrb_q[0]) cfg_d[7:0] = wData_q[7:0];               // [RULE5]
          if (wStrb_q[1]) cfg_d[15:8] = wData_q[15:8];
        end
        PolAddr:
        begin
          if (wStrb_q[0]) pol_d = wData_q[0];
        end
        StatAddr, TimeAddr:
        begin
          bresp_d = RespOkay;
        end
        default:
        begin
          bresp_d = RespSlvErr;
        end
      endcase
    end
    if (bvalid_q && s_axi_bready)
    begin
      bvalid_d = 1'b0;
    end
  end

  always_comb
  begin
    s_axi_awready = !awHeld_q && !bvalid_q;
    s_axi_wready  = !wHeld_q && !bvalid_q;
    s_axi_arready = !rvalid_q;
    s_axi_bvalid  = bvalid_q;
    s_axi_bresp   = bresp_q;
    s_axi_rvalid  = rvalid_q;
    s_axi_rdata   = rdata_q;
    s_axi_rresp   = rresp_q;
    protectionOutput = out_q;
    healthyIndicator = healthy_q;                                  // [RULE7]
  end

  always_comb
  begin
    rvalid_d = rvalid_q;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    if (s_axi_arvalid && !rvalid_q)
    begin
      rvalid_d = 1'b1;
      rresp_d  = RespOkay;
      case (s_axi_araddr & 12'hffc)
        CfgAddr:  rdata_d = {16'h0000, cfg_q};
        StatAddr: rdata_d = 32'(healthy_q) << HealthyBit;          // [RULE7] [RULE8]
        PolAddr:  rdata_d = {31'h0, pol_q};
        TimeAddr: rdata_d = timeRec_q;
        default:
        begin
          rdata_d = 32'h0000_0000;
          rresp_d = RespSlvErr;
        end
      endcase
    end
    else if (rvalid_q && s_axi_rready)
    begin
      rvalid_d = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cfg_q     <= CfgReset;
      pol_q     <= PolReset;
      healthy_q <= 1'b1;
      opTime_q  <= '0;
      opTick_q  <= '0;
      timeRec_q <= '0;
      tick_q    <= '0;
      secs_q    <= '0;
      state_q   <= PoaIdle;
      out_q     <= PolReset;
      awHeld_q  <= 1'b0;
      wHeld_q   <= 1'b0;
      awAddr_q  <= '0;
      wData_q   <= '0;
      wStrb_q   <= '0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RespOkay;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= RespOkay;
    end
    else
    begin
      cfg_q     <= cfg_d;
      pol_q     <= pol_d;
      healthy_q <= healthy_d;
      opTime_q  <= opTime_d;
      opTick_q  <= opTick_d;
      timeRec_q <= timeRec_d;
      tick_q    <= tick_d;
      secs_q    <= secs_d;
      state_q   <= state_d;
      out_q     <= out_d;
      awHeld_q  <= awHeld_d;
      wHeld_q   <= wHeld_d;
      awAddr_q  <= awAddr_d;
      wData_q   <= wData_d;
      wStrb_q   <= wStrb_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
    end
  end
endmodule

// ---- tb/poa_protection_output_asserts.sv ----
// Checker with timing and handshake assertions of the protection output block.
module poa_protection_output_asserts
  import poa_pkg::*;
(
  input wire logic       clk,
  input wire logic       reset_n,
  input wire poa_alarm_t alarmIn,
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       protectionOutput,
  input wire logic       healthyIndicator
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  healthy_sticky_a: assert property (!healthyIndicator |=> !healthyIndicator)
    else $error("healthy indicator came back");
  healthy_drop_a: assert property ((|alarmIn) |-> ##[1:4] !healthyIndicator)
    else $error("healthy indicator kept after alarm");
  healthy_hold_a: assert property ((healthyIndicator && alarmIn == '0) [*4]
    |=> healthyIndicator) else $error("healthy indicator lost without alarm");
  // Five quiet cycles cover the alarm synchroniser and a late polarity update.
  output_quiet_a: assert property ((alarmIn == '0 && !s_axi_wvalid && !s_axi_bvalid) [*5]
    |=> $stable(protectionOutput)) else $error("output moved without cause");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
  write_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  read_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during data");
endmodule

bind poa_protection_output poa_protection_output_asserts poa_protection_output_asserts_inst (
  .clk, .reset_n, .alarmIn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .protectionOutput,
  .healthyIndicator);

// ---- tb/poa_supervision_model.sv ----
// Model of the supervision circuit that senses the open-collector contact.
module poa_supervision_model
(
  input  wire logic protectionOutput,
  output logic      contactClosed
);
  timeunit 1ns;
  timeprecision 1ps;
  // A conducting transistor pulls the sense line low, an open one leaves it at the pull-up.
  logic senseLine;
  assign senseLine     = protectionOutput ? 1'b0 : 1'b1;
  assign contactClosed = !senseLine;
endmodule

// ---- tb/poa_protection_output_tb_top.sv ----
// Self-checking bench of the protection output block.
module poa_protection_output_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import poa_pkg::*;
  logic        clk = 1'b0, reset_n = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        protectionOutput, healthyIndicator, contactClosed;
  poa_alarm_t  alarmIn = '0;
  int          failCount = 0, compares = 0;

  always #12.5 clk = ~clk;

  poa_protection_output #(.SecCycles(20)) poa_protection_output_inst (.clk, .reset_n, .alarmIn,
    .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .protectionOutput,
    .healthyIndicator);
  poa_supervision_model poa_supervision_model_inst (.protectionOutput, .contactClosed);

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failCount++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    check({30'h0, s_axi_bresp}, {30'h0, r});
    s_axi_bready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    check(s_axi_rdata, e);
    check({30'h0, s_axi_rresp}, {30'h0, r});
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask

  // Alarms change right after an edge and the contact is judged n cycles later.
  task automatic hold(input logic [6:0] al, input int n, input logic exp);
    alarmIn <= poa_alarm_t'(al);
    repeat (n) @(posedge clk);
    check({31'h0, contactClosed}, {31'h0, exp});
  endtask

  task automatic test_done;
    $display("compares %0d mismatches %0d", compares, failCount);
    if (failCount == 0 && compares > 0)
    begin
      $display("ALL CHECKS OK");
    end
    else
    begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial
  begin
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    check({30'h0, contactClosed, healthyIndicator}, 32'h3);
    rd(StatAddr, 32'h800, RespOkay);
    rd(CfgAddr, {16'h0, CfgReset}, RespOkay);
    rd(12'h0f0, 32'h0, RespSlvErr);
    wr(12'h0f0, 32'h1, RespSlvErr);
    wr(CfgAddr, 32'h2, RespOkay);
    hold(7'h7e, 12, 1'b1);
    check({31'h0, healthyIndicator}, 32'h0);
    rd(StatAddr, 32'h0, RespOkay);
    // With 20 cycles a second the first alarm is seen during the second second of service.
    rd(TimeAddr, 32'h1, RespOkay);
    hold(7'h0, 6, 1'b1);
    for (int i = 0; i < 7; i++)
    begin
      wr(CfgAddr, 32'h1000 | (32'h2 << i), RespOkay);
      rd(CfgAddr, 32'h1000 | (32'h2 << i), RespOkay);
      hold(7'h1 << i, 12, 1'b1);
      hold(7'h1 << i, 20, 1'b0);
      hold(7'h0, 6, 1'b1);
    end
    wr(CfgAddr, 32'hf002, RespOkay);
    hold(7'h1, 290, 1'b1);
    hold(7'h1, 30, 1'b0);
    hold(7'h0, 6, 1'b1);
    wr(CfgAddr, 32'h1002, RespOkay);
    hold(7'h1, 15, 1'b1);
    hold(7'h0, 5, 1'b1);
    hold(7'h1, 15, 1'b1);
    hold(7'h1, 20, 1'b0);
    hold(7'h0, 6, 1'b1);
    wr(CfgAddr, 32'h0f00, RespOkay);
    hold(7'h7f, 12, 1'b1);
    rd(PolAddr, 32'h1, RespOkay);
    wr(PolAddr, 32'h0, RespOkay);
    hold(7'h0, 4, 1'b0);
    rd(PolAddr, 32'h0, RespOkay);
    wr(CfgAddr, 32'h2, RespOkay);
    hold(7'h1, 10, 1'b1);
    hold(7'h0, 6, 1'b0);
    // The record is read-only and is taken only once, at the first alarm.
    wr(TimeAddr, 32'hffff, RespOkay);
    rd(TimeAddr, 32'h1, RespOkay);
    // Only the low byte lane is written, so the upper byte keeps zero.
    s_axi_wstrb <= 4'h1;
    wr(CfgAddr, 32'h5555, RespOkay);
    s_axi_wstrb <= 4'hf;
    rd(CfgAddr, 32'h55, RespOkay);
    test_done;
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    failCount++;
    test_done;
  end
endmodule
